// ---- usb_endpoint_status_control.sv ----
// Endpoint control, transfer status queue and packet RAM window of a USB device
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "usb_consts.svh"
// How it works
// - Status shows endpoint, direction, bank; bits 7,0 zero
// - Status reads the head of a four-entry queue
// - Later completions are queued, discarded while the queue is full unless a flag clear pops it in the same cycle
// - Clearing flag advances queue, re-sets within 5 cycles
// - Empty queue leaves flag clear after clearing
// - Full queue makes endpoint requests answer NAK
// - Direction bit is 1 for IN, else 0
// - Bank bit is 1 for odd, 0 for even
// - Sixteen endpoint registers, bits 7-5 zero, reset zero
// - Handshake enable bit gates all handshakes
// - Setup disable blocks SETUP when both directions enabled
// - Out and in enable bits gate each direction
// - Stall bit set on STALL, cleared by firmware
// - Address register clears on bus or CPU reset
// - Frame number is 11 bits over two registers
// - Frame number loads on SOF, read-only
// - One-kilobyte dual-port RAM at 400h to 7FFh
// - Bank 400h-4FFh holds descriptors, rest holds data
// - Descriptors live only once in enable is set
module usb_endpoint_status_control
  import usb_pkg::*;
#(
  parameter int QUEUE_DEPTH = `QUEUE_DEPTH
)(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite register port
  input  wire logic [12:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic      [1:0]              s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [12:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Completed transfers from the engine
  input  wire logic                    xfer_done,
  input  wire logic [3:0]              xfer_ep,
  input  wire logic                    xfer_dir,
  input  wire logic                    xfer_pingpong_bank_indicator,
  // Token requests and handshake decisions
  input  wire logic                    tok_valid,
  input  wire logic [3:0]              tok_ep,
  input  wire token_type               tok_kind,
  input  wire logic                    tok_bd_stall,
  input  wire logic                    tok_bd_owned,
  output logic                         hs_valid,
  output handshake_type                hs_kind,
  // Frame and bus reset events
  input  wire logic                    sof_valid,
  input  wire logic [`FRAME_WIDTH-1:0] sof_frame,
  input  wire logic                    bus_reset,
  // Engine packet RAM port
  input  wire logic                    eng_ram_we,
  input  wire logic [9:0]              eng_ram_addr,
  input  wire logic [7:0]              eng_ram_wdata,
  output logic      [7:0]              eng_ram_rdata,
  output logic                         eng_desc_live,
  // State seen by the engine
  output logic      [7:0]              device_bus_address,
  output logic                         transfer_complete_flag,
  output logic                         bus_reset_flag
);
  localparam int REFLAG_MAX = `REFLAG_CYC - 1;

  status_queue_if q ();

  logic                    aw_have_r;
  logic                    w_have_r;
  logic                    bvalid_r;
  logic                    rvalid_r;
  logic [12:0]             waddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic [1:0]              bresp_r;
  logic [1:0]              rresp_r;
  logic [7:0]              rdata_r;
  logic                    wr_fire;
  logic                    rd_fire;
  logic                    wr_ram;
  logic                    wr_ep;
  logic                    wr_known;
  logic                    wr_lane0;
  logic                    rd_ok;
  logic [7:0]              rd_byte;
  logic [7:0]              st_byte;
  logic [7:0]              cpu_rdata;
  logic [9:0]              cpu_addr;
  logic [4:0]              ep_ctl_r [16];
  logic [4:0]              tok_ctl;
  logic                    tok_allowed;
  logic                    stall_set;
  handshake_type           hs_nxt;
  logic                    hs_valid_r;
  handshake_type           hs_kind_r;
  logic                    trn_flag_r;
  logic                    rst_flag_r;
  logic                    clr_trn;
  logic                    clr_rst;
  status_entry_type        status_r;
  logic [7:0]              devaddr_r;
  logic [`FRAME_WIDTH-1:0] frame_r;
  logic                    desc_live_r;

  status_queue #(
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (q.queue)
  );

  usb_ram #(
    .BYTES (`RAM_BYTES),
    .AW    (10)
  ) u_ram (
    .aclk      (aclk),
    .cpu_we    (wr_fire && wr_ram && wr_lane0),
    .cpu_addr  (cpu_addr),
    .cpu_wdata (wdata_r[7:0]),
    .cpu_rdata (cpu_rdata),
    .eng_we    (eng_ram_we),
    .eng_addr  (eng_ram_addr),
    .eng_wdata (eng_ram_wdata),
    .eng_rdata (eng_ram_rdata)
  );

  // Bus handshakes; a read waits while a write is being applied
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r && !wr_fire;
  assign wr_fire       = aw_have_r && w_have_r;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      waddr_r   <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      waddr_r   <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Write decode; only byte lane 0 carries register data
  assign wr_lane0 = wstrb_r[0];
  assign wr_ram   = waddr_r[12:2] >= `RAM_INDEX_LO;
  assign wr_ep    = {waddr_r[12:6], 6'h00} == `EP_CTL_BASE;
  assign wr_known = wr_ram || wr_ep
                    || {waddr_r[12:2], 2'b00} == `STATUS_ADDR
                    || {waddr_r[12:2], 2'b00} == `FLAGS_ADDR
                    || {waddr_r[12:2], 2'b00} == `DEVADDR_ADDR
                    || {waddr_r[12:2], 2'b00} == `FRAME_LO_ADDR
                    || {waddr_r[12:2], 2'b00} == `FRAME_HI_ADDR;
  assign clr_trn  = wr_fire && wr_lane0 && trn_flag_r && wdata_r[`FLAG_TRN_BIT]
                    && {waddr_r[12:2], 2'b00} == `FLAGS_ADDR;
  assign clr_rst  = wr_fire && wr_lane0 && wdata_r[`FLAG_RST_BIT]
                    && {waddr_r[12:2], 2'b00} == `FLAGS_ADDR;
  assign cpu_addr = wr_fire ? waddr_r[11:2] : s_axi_araddr[11:2];

  // Status byte layout with unused bits held at zero
  always_comb begin
    st_byte                        = 8'h00;
    st_byte[`ST_EP_LSB +: 4]       = status_r.ep;
    st_byte[`ST_DIR_BIT]           = status_r.dir;
    st_byte[`ST_PPB_BIT]           = status_r.pingpong_bank_indicator;
  end

  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (s_axi_araddr[12:2] >= `RAM_INDEX_LO) begin
      rd_byte = cpu_rdata;
    end else if ({s_axi_araddr[12:6], 6'h00} == `EP_CTL_BASE) begin
      rd_byte = {3'h0, ep_ctl_r[s_axi_araddr[5:2]]};
    end else begin
      case ({s_axi_araddr[12:2], 2'b00})
        `STATUS_ADDR:   rd_byte = st_byte;
        `FLAGS_ADDR:    rd_byte = {6'h00, rst_flag_r, trn_flag_r};
        `DEVADDR_ADDR:  rd_byte = devaddr_r;
        `FRAME_LO_ADDR: rd_byte = frame_r[7:0];
        `FRAME_HI_ADDR: rd_byte = {5'h00, frame_r[10:8]};
        default:        rd_ok   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_byte;
      rresp_r  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Completed transfers enter the queue; the head shows once the flag sets
  assign q.push      = xfer_done;
  assign q.push_data = '{ep: xfer_ep, dir: xfer_dir, pingpong_bank_indicator: xfer_pingpong_bank_indicator};
  assign q.pop       = clr_trn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trn_flag_r <= 1'b0;
    end else if (clr_trn) begin
      trn_flag_r <= 1'b0;
    end else if (!q.empty) begin
      trn_flag_r <= 1'b1;
    end
  end

  // Holds the last entry after the queue drains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else if (!trn_flag_r && !clr_trn && !q.empty) begin
      status_r <= q.head;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_flag_r <= 1'b0;
    end else if (bus_reset) begin
      rst_flag_r <= 1'b1;
    end else if (clr_rst) begin
      rst_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      devaddr_r <= `DEVADDR_RESET;
    end else if (bus_reset) begin
      devaddr_r <= `DEVADDR_RESET;
    end else if (wr_fire && wr_lane0 && {waddr_r[12:2], 2'b00} == `DEVADDR_ADDR) begin
      devaddr_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_r <= '0;
    end else if (sof_valid) begin
      frame_r <= sof_frame;
    end
  end

  // Token screening and handshake choice
  assign tok_ctl = ep_ctl_r[tok_ep];

  always_comb begin
    unique case (tok_kind)
      TOK_IN:    tok_allowed = tok_ctl[`EP_INEN_BIT];
      TOK_OUT:   tok_allowed = tok_ctl[`EP_OUTEN_BIT];
      TOK_SETUP: tok_allowed = tok_ctl[`EP_OUTEN_BIT]
                               && !(tok_ctl[`EP_INEN_BIT] && tok_ctl[`EP_SETUPDIS_BIT]);
      default:   tok_allowed = 1'b0;
    endcase
  end

  always_comb begin
    if (!tok_allowed) begin
      hs_nxt = HS_IGNORE;
    end else if (!tok_ctl[`EP_HSHK_BIT]) begin
      hs_nxt = HS_NONE;
    end else if (q.full) begin
      hs_nxt = HS_NAK;
    end else if (tok_bd_stall) begin
      hs_nxt = HS_STALL;
    end else if (!tok_bd_owned) begin
      hs_nxt = HS_NAK;
    end else begin
      hs_nxt = HS_ACK;
    end
  end

  assign stall_set = tok_valid && hs_nxt == HS_STALL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_valid_r <= 1'b0;
      hs_kind_r  <= HS_NONE;
    end else begin
      hs_valid_r <= tok_valid;
      if (tok_valid) begin
        hs_kind_r <= hs_nxt;
      end
    end
  end

  // Endpoint registers; a stall report wins over a firmware write
  for (genvar i = 0; i < 16; i++) begin : g_ep
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ep_ctl_r[i] <= `EP_CTL_RESET;
      end else begin
        if (wr_fire && wr_ep && wr_lane0 && waddr_r[5:2] == 4'(i)) begin
          ep_ctl_r[i] <= wdata_r[4:0];
        end
        if (stall_set && tok_ep == 4'(i)) begin
          ep_ctl_r[i][`EP_STALL_BIT] <= 1'b1;
        end
      end
    end
  end

  // Descriptor bytes act as descriptors only for in-enabled endpoints
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_live_r <= 1'b0;
    end else begin
      desc_live_r <= ({1'b1, eng_ram_addr} <= `DESC_INDEX_HI)
                     && ep_ctl_r[eng_ram_addr[7:4]][`EP_INEN_BIT];
    end
  end

  assign hs_valid               = hs_valid_r;
  assign hs_kind                = hs_kind_r;
  assign eng_desc_live          = desc_live_r;
  assign device_bus_address     = devaddr_r;
  assign transfer_complete_flag = trn_flag_r;
  assign bus_reset_flag         = rst_flag_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  status_head_a: assert property ($rose(trn_flag_r) |-> status_r == $past(q.head))
    else $error("status does not show queue head");
  status_zero_a: assert property (rvalid_r && $past(rd_fire)
      && {$past(s_axi_araddr[12:2]), 2'b00} == `STATUS_ADDR
      |-> !rdata_r[7] && !rdata_r[0])
    else $error("status unused bits not zero");
  queue_push_a: assert property (xfer_done && !q.full |=> !q.empty)
    else $error("completion lost");
  reflag_time_a: assert property (clr_trn ##1 !q.empty |-> ##[1:REFLAG_MAX] trn_flag_r)
    else $error("flag not set again in time");
  flag_stays_a: assert property (clr_trn ##1 (q.empty && !xfer_done) |=> !trn_flag_r)
    else $error("flag set with empty queue");
  full_nak_a: assert property (tok_valid && tok_allowed && tok_ctl[`EP_HSHK_BIT] && q.full
      |=> hs_valid && hs_kind == HS_NAK)
    else $error("full queue did not NAK");
  dir_bit_a: assert property (xfer_done && q.empty && !trn_flag_r
      |-> ##2 status_r.dir == $past(xfer_dir, 2))
    else $error("direction bit wrong");
  no_hshk_a: assert property (tok_valid && tok_allowed && !tok_ctl[`EP_HSHK_BIT]
      |=> hs_kind == HS_NONE)
    else $error("handshake sent while disabled");
  setup_block_a: assert property (tok_valid && tok_kind == TOK_SETUP
      && tok_ctl[`EP_INEN_BIT] && tok_ctl[`EP_OUTEN_BIT] && tok_ctl[`EP_SETUPDIS_BIT]
      |=> hs_kind == HS_IGNORE)
    else $error("setup not blocked");
  stall_mark_a: assert property (stall_set |=> ep_ctl_r[$past(tok_ep)][`EP_STALL_BIT])
    else $error("stall bit not set");
  addr_clear_a: assert property (bus_reset |=> devaddr_r == `DEVADDR_RESET)
    else $error("address not cleared on bus reset");
  frame_load_a: assert property (sof_valid |=> frame_r == $past(sof_frame))
    else $error("frame number not loaded");

  reflag_seen_c: cover property (clr_trn ##1 !q.empty ##[1:3] trn_flag_r);
  full_nak_c: cover property (hs_valid && hs_kind == HS_NAK && q.full);
  stall_seen_c: cover property (stall_set ##1 ep_ctl_r[1][`EP_STALL_BIT]);
endmodule

// ---- usb_consts.svh ----
// Offsets, field positions, reset values and timing counts of the USB control block
`ifndef USB_CONSTS_SVH
`define USB_CONSTS_SVH
`define STATUS_ADDR      13'h0000
`define FLAGS_ADDR       13'h0004
`define DEVADDR_ADDR     13'h0008
`define FRAME_LO_ADDR    13'h000c
`define FRAME_HI_ADDR    13'h0010
`define EP_CTL_BASE      13'h0040
`define RAM_INDEX_LO     11'h400
`define RAM_INDEX_HI     11'h7ff
`define DESC_INDEX_HI    11'h4ff
`define DESC_MIN_BYTES   8'h08
`define FLAG_TRN_BIT     0
`define FLAG_RST_BIT     1
`define ST_EP_LSB        3
`define ST_DIR_BIT       2
`define ST_PPB_BIT       1
`define EP_HSHK_BIT      4
`define EP_SETUPDIS_BIT  3
`define EP_OUTEN_BIT     2
`define EP_INEN_BIT      1
`define EP_STALL_BIT     0
`define EP_CTL_RESET     5'h00
`define DEVADDR_RESET    8'h00
`define FRAME_WIDTH      11
`define QUEUE_DEPTH      4
`define RAM_BYTES        1024
`define REFLAG_TCY       5
`define INSTR_CYCLE_NS   4
`define CLK_PERIOD_NS    4
`define REFLAG_CYC       ((`REFLAG_TCY * `INSTR_CYCLE_NS) / `CLK_PERIOD_NS)
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// ---- usb_pkg.sv ----
// Types shared by the USB control block files
package usb_pkg;
  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_type;
  typedef enum logic [2:0] {HS_ACK, HS_NAK, HS_STALL, HS_NONE, HS_IGNORE} handshake_type;
  typedef struct packed {
    logic [3:0] ep;
    logic       dir;
    logic       pingpong_bank_indicator;
  } status_entry_type;
endpackage

// ---- status_queue_if.sv ----
// Carrier between the control block and its transfer status queue
`timescale 1ns/100ps
interface status_queue_if;
  import usb_pkg::*;
  logic             push;
  status_entry_type push_data;
  logic             pop;
  status_entry_type head;
  logic             full;
  logic             empty;
  modport owner (output push, push_data, pop, input head, full, empty);
  modport queue (input push, push_data, pop, output head, full, empty);
endinterface

// ---- status_queue.sv ----
// Transfer status queue held in flip-flops
`timescale 1ns/100ps
`include "usb_consts.svh"
module status_queue
  import usb_pkg::*;
#(
  parameter int DEPTH = `QUEUE_DEPTH
)(
  // Clock and reset
  input wire logic      aclk,
  input wire logic      aresetn,
  // Queue port
  status_queue_if.queue q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  status_entry_type mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             do_push;
  logic             do_pop;

  assign do_pop  = q.pop && !q.empty;
  assign do_push = q.push && (!q.full || do_pop);
  assign q.full  = (count_r == CW'(DEPTH));
  assign q.empty = (count_r == '0);
  assign q.head  = mem_r[rd_ptr_r];

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= q.push_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

// ---- usb_ram.sv ----
// Dual-port packet memory shared by the CPU and the serial interface engine
`timescale 1ns/100ps
`include "usb_consts.svh"
module usb_ram #(
  parameter int BYTES = `RAM_BYTES,
  parameter int AW    = 10
)(
  // Clock
  input  wire logic          aclk,
  // CPU port, read without latency
  input  wire logic          cpu_we,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [7:0]    cpu_wdata,
  output logic      [7:0]    cpu_rdata,
  // Engine port, read one cycle late
  input  wire logic          eng_we,
  input  wire logic [AW-1:0] eng_addr,
  input  wire logic [7:0]    eng_wdata,
  output logic      [7:0]    eng_rdata
);
  logic [7:0] mem_r [BYTES];

  // Engine wins a same-address write collision
  always_ff @(posedge aclk) begin
    if (eng_we) begin
      mem_r[eng_addr] <= eng_wdata;
    end
    if (cpu_we && !(eng_we && eng_addr == cpu_addr)) begin
      mem_r[cpu_addr] <= cpu_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    eng_rdata <= mem_r[eng_addr];
  end

  assign cpu_rdata = mem_r[cpu_addr];
endmodule

// ---- host_model.sv ----
// Far-side model: engine events, host tokens and engine RAM reads
`timescale 1ns/100ps
module host_model
  import usb_pkg::*;
(
  // Clock
  input  wire logic          aclk,
  // Engine and host events
  output logic               xfer_done,
  output logic [3:0]         xfer_ep,
  output logic               xfer_dir,
  output logic               xfer_pingpong_bank_indicator,
  output logic               tok_valid,
  output logic [3:0]         tok_ep,
  output token_type          tok_kind,
  output logic               tok_bd_stall,
  output logic               tok_bd_owned,
  output logic               sof_valid,
  output logic [10:0]        sof_frame,
  output logic               bus_reset,
  output logic [9:0]         eng_ram_addr,
  // Answers of the block
  input  wire logic          hs_valid,
  input  wire handshake_type hs_kind,
  input  wire logic [7:0]    eng_ram_rdata,
  input  wire logic          eng_desc_live
);
  initial begin
    {xfer_done, xfer_ep, xfer_dir, xfer_pingpong_bank_indicator, tok_valid, tok_ep} = '0;
    {tok_bd_stall, tok_bd_owned, sof_valid, sof_frame, bus_reset, eng_ram_addr} = '0;
    tok_kind = TOK_OUT;
  end
  task fin(input logic [3:0] e, input logic d, input logic p);
    @(posedge aclk);
    {xfer_done, xfer_ep, xfer_dir, xfer_pingpong_bank_indicator} <= {1'b1, e, d, p};
    @(posedge aclk);
    {xfer_done, xfer_ep} <= {1'b0, ~e};
  endtask
  task tok(input logic [3:0] e, input token_type t, input logic s, input logic o,
           output handshake_type k);
    @(posedge aclk);
    {tok_valid, tok_ep, tok_bd_stall, tok_bd_owned} <= {1'b1, e, s, o};
    tok_kind <= t;
    @(posedge aclk);
    {tok_valid, tok_ep} <= {1'b0, ~e};
    @(negedge aclk);
    k = hs_valid ? hs_kind : handshake_type'(3'h7);
  endtask
  task sof(input logic [10:0] f);
    @(posedge aclk);
    {sof_valid, sof_frame} <= {1'b1, f};
    @(posedge aclk);
    {sof_valid, sof_frame} <= {1'b0, ~f};
  endtask
  task breset;
    @(posedge aclk);
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
  endtask
  task peek(input logic [9:0] a, output logic [7:0] d, output logic l);
    @(posedge aclk);
    eng_ram_addr <= a;
    @(posedge aclk);
    @(negedge aclk);
    d = eng_ram_rdata;
    l = eng_desc_live;
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench of the USB endpoint and status control block
`timescale 1ns/100ps
`include "usb_consts.svh"
module testbench
  import usb_pkg::*;
;
  logic          aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic          s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, eng_ram_we = 0;
  logic [12:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]   s_axi_wdata = '0, s_axi_rdata, rdv;
  logic [3:0]    s_axi_wstrb = 4'h1, xfer_ep, tok_ep;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic          xfer_done, xfer_dir, xfer_pingpong_bank_indicator, tok_valid, tok_bd_stall, tok_bd_owned;
  logic          sof_valid, bus_reset, hs_valid, eng_desc_live, pl;
  logic          transfer_complete_flag, bus_reset_flag;
  logic [10:0]   sof_frame;
  logic [9:0]    eng_ram_addr;
  logic [7:0]    eng_ram_wdata = '0, eng_ram_rdata, device_bus_address, pd;
  token_type     tok_kind;
  handshake_type hs_kind, hk;
  int            fails = 0, n_compared = 0;
  logic [3:0]    qe [5] = '{4'd3, 4'd5, 4'd15, 4'd0, 4'd9};
  logic          qd [5] = '{1, 0, 1, 0, 1};
  logic          qp [5] = '{1, 0, 0, 1, 0};
  usb_endpoint_status_control usb_endpoint_status_control_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_done,
    .xfer_ep, .xfer_dir, .xfer_pingpong_bank_indicator, .tok_valid, .tok_ep, .tok_kind, .tok_bd_stall,
    .tok_bd_owned, .hs_valid, .hs_kind, .sof_valid, .sof_frame, .bus_reset, .eng_ram_we,
    .eng_ram_addr, .eng_ram_wdata, .eng_ram_rdata, .eng_desc_live, .device_bus_address,
    .transfer_complete_flag, .bus_reset_flag);
  host_model host_model_inst (.aclk, .xfer_done, .xfer_ep, .xfer_dir, .xfer_pingpong_bank_indicator, .tok_valid,
    .tok_ep, .tok_kind, .tok_bd_stall, .tok_bd_owned, .sof_valid, .sof_frame, .bus_reset,
    .eng_ram_addr, .hs_valid, .hs_kind, .eng_ram_rdata, .eng_desc_live);
  always #2 aclk = ~aclk;
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    logic at, wt, bd;
    bd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!bd) begin
      @(negedge aclk);
      at = s_axi_awready & s_axi_awvalid;
      wt = s_axi_wready & s_axi_wvalid;
      bd = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 0;
      if (wt) s_axi_wvalid <= 0;
      if (bd) s_axi_bready <= 0;
    end
  endtask
  task rd(input logic [12:0] a);
    logic at, rv;
    rv = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!rv) begin
      @(negedge aclk);
      at = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      rdv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 0;
      if (rv) s_axi_rready <= 0;
    end
  endtask
  task rc(input logic [12:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rdv);
  endtask
  // Program endpoint 1, send one token, compare the handshake
  task tt(input logic [7:0] c, input token_type t, input logic s, input logic o,
          input handshake_type e);
    wr(`EP_CTL_BASE + 13'h4, c);
    host_model_inst.tok(4'd1, t, s, o, hk);
    chk("handshake", e, hk);
  endtask
  function automatic logic [31:0] sx(input logic [3:0] e, input logic d, input logic p);
    return {24'h0, 1'b0, e, d, p, 1'b0};
  endfunction
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    int n;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rc(`DEVADDR_ADDR, 0, "address reset");
    for (int i = 0; i < 16; i++) rc(`EP_CTL_BASE + 13'(4 * i), 0, "endpoint reset");
    wr(`EP_CTL_BASE + 13'h3c, 8'hff);
    rc(`EP_CTL_BASE + 13'h3c, 32'h1f, "endpoint 15");
    wr(`DEVADDR_ADDR, 8'h5a);
    rc(`DEVADDR_ADDR, 32'h5a, "address");
    chk("address pin", 32'h5a, device_bus_address);
    host_model_inst.breset();
    rc(`DEVADDR_ADDR, 0, "address after bus reset");
    rc(`FLAGS_ADDR, 32'h2, "bus reset flag");
    chk("bus reset pin", 1, bus_reset_flag);
    wr(`FLAGS_ADDR, 8'h02);
    host_model_inst.sof(11'h5a3);
    wr(`FRAME_LO_ADDR, 8'hff);
    rc(`FRAME_LO_ADDR, 32'ha3, "frame low");
    rc(`FRAME_HI_ADDR, 32'h05, "frame high");
    wr(13'h0020, 8'h11);
    chk("unmapped write", `RESP_SLVERR, rs);
    rd(13'h0020);
    chk("unmapped read", `RESP_SLVERR, rs);
    tt(8'h00, TOK_OUT, 0, 1, HS_IGNORE);
    tt(8'h04, TOK_OUT, 0, 1, HS_NONE);
    tt(8'h14, TOK_OUT, 0, 1, HS_ACK);
    tt(8'h14, TOK_OUT, 0, 0, HS_NAK);
    tt(8'h12, TOK_OUT, 0, 1, HS_IGNORE);
    tt(8'h12, TOK_IN, 0, 1, HS_ACK);
    tt(8'h1e, TOK_SETUP, 0, 1, HS_IGNORE);
    tt(8'h16, TOK_SETUP, 0, 1, HS_ACK);
    tt(8'h16, TOK_IN, 1, 1, HS_STALL);
    host_model_inst.tok(4'd1, TOK_IN, 0, 1, hk);
    rc(`EP_CTL_BASE + 13'h4, 32'h17, "stall held");
    wr(`EP_CTL_BASE + 13'h4, 8'h16);
    rc(`EP_CTL_BASE + 13'h4, 32'h16, "stall cleared");
    wr(`EP_CTL_BASE, 8'h16);
    host_model_inst.tok(4'd0, TOK_SETUP, 0, 1, hk);
    chk("endpoint 0 setup", HS_ACK, hk);
    wr(`EP_CTL_BASE + 13'h8, 8'h14);
    for (int i = 0; i < 5; i++) host_model_inst.fin(qe[i], qd[i], qp[i]);
    host_model_inst.tok(4'd2, TOK_OUT, 0, 1, hk);
    chk("full queue", HS_NAK, hk);
    for (int i = 0; i < 4; i++) begin
      chk("complete flag", 1, transfer_complete_flag);
      rc(`STATUS_ADDR, sx(qe[i], qd[i], qp[i]), "status");
      wr(`FLAGS_ADDR, 8'h01);
      n = 0;
      while (transfer_complete_flag !== 1'b1 && n < 5) begin
        @(negedge aclk);
        n++;
      end
    end
    chk("flag after empty", 0, transfer_complete_flag);
    rc(`STATUS_ADDR, sx(qe[3], qd[3], qp[3]), "status kept");
    wr(13'h1440, 8'h3c);
    rc(13'h1440, 32'h3c, "ram cpu");
    host_model_inst.peek(10'h110, pd, pl);
    chk("ram engine", 8'h3c, pd);
    chk("data bank", 0, pl);
    host_model_inst.peek(10'h010, pd, pl);
    chk("descriptor live", 1, pl);
    host_model_inst.peek(10'h020, pd, pl);
    chk("descriptor idle", 0, pl);
    // Engine port writes the byte the model still addresses
    @(posedge aclk);
    {eng_ram_we, eng_ram_wdata} <= {1'b1, 8'hc5};
    @(posedge aclk);
    eng_ram_we <= 1'b0;
    rc(13'h1080, 32'hc5, "ram engine write");
    stop_test();
  end
endmodule
